// *** bench/chan_cfg_checker.sv ***
/* Port checker of the channel configuration block.
   Assumes it is bound to every chan_cfg instance. */
module chan_cfg_checker #(
  parameter int RST_CYCLES  = 20,
  parameter int CONV_CYCLES = 4
) (
  // Clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Outputs watched
  input wire logic [7:0]  chan_oe,
  input wire logic        int_ref_enable,
  input wire logic        sampling_switch,
  input wire logic        converting,
  input wire logic        device_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted writes, and writes that set the reference bit
  wire wr     = psel && penable && pwrite;
  wire ref_wr = wr && paddr == 12'h014 && pwdata[1];
  logic [31:0] conv_len_q;
  logic [31:0] rst_len_q;
  // Length of the running conversion and soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_len_q <= 32'h0;
      rst_len_q  <= 32'h0;
    end else begin
      conv_len_q <= converting ? conv_len_q + 32'h1 : 32'h0;
      rst_len_q  <= device_reset ? rst_len_q + 32'h1 : 32'h0;
    end
  end
  AST_CHAN_RST: assert property ($rose(presetn) |-> chan_oe == 8'h00)
    else $error("channel driven after reset");
  AST_OE_CAUSE: assert property ($changed(chan_oe) |-> $past(wr) ||
    $past(wr, 2) || $past(device_reset) || $past(device_reset, 2))
    else $error("drive enable changed without a write");
  AST_REF_CAUSE: assert property ($rose(int_ref_enable) |->
    $past(ref_wr) || $past(ref_wr, 2)) else $error("reference on unasked");
  AST_REF_DFLT: assert property ($fell(device_reset) |-> ##[0:1]
    !int_ref_enable) else $error("reference on after soft reset");
  AST_RST_LEN: assert property (rst_len_q <= RST_CYCLES + 2)
    else $error("soft reset too long");
  AST_CONV_LEN: assert property (conv_len_q <= CONV_CYCLES)
    else $error("conversion too long");
  AST_CONV_END: assert property ($fell(converting) |-> sampling_switch)
    else $error("no acquisition after conversion");
  AST_SW_PHASE: assert property (sampling_switch != converting)
    else $error("switch state wrong for phase");
  CVR_CONV: cover property ($fell(converting));
  CVR_SRST: cover property ($fell(device_reset));
  CVR_REF: cover property ($rose(int_ref_enable));
endmodule // chan_cfg_checker

bind chan_cfg chan_cfg_checker #(
  .RST_CYCLES(RST_CYCLES), .CONV_CYCLES(CONV_CYCLES)
) u_chan_cfg_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .chan_oe(chan_oe),
  .int_ref_enable(int_ref_enable), .sampling_switch(sampling_switch),
  .converting(converting), .device_reset(device_reset)
);

// *** bench/chan_cfg_tb.sv ***
/* Testbench of chan_cfg: APB tasks drive it, a pad model faces the pins.
   Assumes short soft reset (20) and conversion (4) counts. */
module chan_cfg_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, int_ref_enable, sampling_switch;
  logic converting, device_reset;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic serr;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] chan_in, chan_out, chan_oe, ext_lvl = 8'h00, ext_en = 8'h00;
  int bad_count = 0, n_compared = 0, n;
  always #5 pclk = ~pclk;
  chan_cfg #(.RST_CYCLES(20), .CONV_CYCLES(4)) u_chan_cfg (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_in(chan_in), .chan_out(chan_out), .chan_oe(chan_oe),
    .int_ref_enable(int_ref_enable), .sampling_switch(sampling_switch),
    .converting(converting), .device_reset(device_reset));
  chan_pads u_chan_pads (.chan_out(chan_out), .chan_oe(chan_oe),
    .ext_lvl(ext_lvl), .ext_en(ext_en), .lvl(chan_in));
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick;
    @(posedge pclk);
    #1;
  endtask
  // One APB transfer; read data and error are taken at the access edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk("register", rdata, e);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) rchk(12'(a), 32'h0);
    chk("enables", chan_oe, 32'h0);
    xfer(1'b1, 12'h000, 32'hFF);
    xfer(1'b1, 12'h004, 32'h0F);
    xfer(1'b1, 12'h008, 32'h03);
    @(posedge pclk);
    ext_en <= 8'hF0;
    ext_lvl <= 8'hA5;
    xfer(1'b1, 12'h00C, 32'h05);
    tick;
    tick;
    chk("enables", chan_oe, 32'h0B);
    chk("wires", chan_in, 32'hA5);
    rchk(12'h010, 32'hA0);
    xfer(1'b1, 12'h000, 32'h0F);
    rchk(12'h010, 32'h00);
    chk("error", serr, 32'h0);
    xfer(1'b1, 12'h0F0, 32'h00);
    chk("error", serr, 32'h1);
    rchk(12'h000, 32'h0F);
    xfer(1'b1, 12'h000, 32'h00);
    tick;
    tick;
    chk("enables", chan_oe, 32'h0);
    xfer(1'b1, 12'h014, 32'h2);
    tick;
    chk("reference", int_ref_enable, 32'h1);
    xfer(1'b1, 12'h01C, 32'h1);
    for (n = 0; n < 50 && converting !== 1'b1; n++) tick;
    for (n = 0; n < 50 && converting === 1'b1; n++) tick;
    chk("conversion", n <= 4 && n > 0, 32'h1);
    chk("switch", sampling_switch, 32'h1);
    xfer(1'b1, 12'h014, 32'h3);
    for (n = 0; n < 10 && device_reset !== 1'b1; n++) tick;
    for (n = 0; n < 99 && device_reset === 1'b1; n++) tick;
    chk("soft reset", n <= 22, 32'h1);
    chk("reference", int_ref_enable, 32'h0);
    rchk(12'h014, 32'h0);
    rchk(12'h008, 32'h0);
    report_and_stop;
  end
endmodule // chan_cfg_tb

// *** bench/chan_pads.sv ***
/* Board model of the eight channel wires.
   Assumes a pull-up on every wire and that the bench picks the far drive. */
module chan_pads (
  // Block side
  input  wire logic [7:0] chan_out,
  input  wire logic [7:0] chan_oe,
  // Far side
  input  wire logic [7:0] ext_lvl,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clash gives unknown, an idle wire floats high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lvl[i] = (chan_oe[i] && ext_en[i]) ? 1'bx : chan_oe[i] ? chan_out[i]
             : ext_en[i] ? ext_lvl[i] : 1'b1;
    end
  end
endmodule // chan_pads

// *** core/chan_cfg.sv ***
/*
  Eight-channel converter front-end configuration with APB registers.
  Each channel is analog input, digital input or digital output.
  Assumes pin inputs are asynchronous and external pads combine the
  output and enable into the wire level.
*/
// Our own choices: the register addresses and the APB slave port.
// Overview of operation
// - Reset puts all channels analog.
// - Per-channel analog or digital select.
// - Per-channel direction for digital channels.
// - Input register reads sampled input levels.
// - Output register sets driven output levels.
// - Per-channel open-drain or push-pull drive.
// - Reset selects external reference only.
// - Internal reference on only when bit set.
// - Reset bit self-clears within five ms.
// - Conversion timed internally, within 950 ns.
// - Return to acquisition after conversion.
// - Switch closed acquiring, open converting.
`include "chan_cfg_consts.svh"

module chan_cfg #(
  parameter int RST_CYCLES  = `RST_CYCLES,
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Channel pins
  input  wire logic [7:0]  chan_in,
  output logic      [7:0]  chan_out,
  output logic      [7:0]  chan_oe,
  // Analog front-end controls
  output logic             int_ref_enable,
  output logic             sampling_switch,
  output logic             converting,
  output logic             device_reset
);

  // Current and next state
  chan_cfg_pkg::state_t s_q;
  chan_cfg_pkg::state_t s_d;
  // Bus strobes
  logic wr_en;
  logic rd_setup;

  // Access phase of a transfer; the slave answers with no wait
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite;
  // Read data are fetched in the setup cycle so they stand at the access edge
  assign rd_setup = psel & ~penable & ~pwrite;

  // Decode of mapped offsets
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFF_PIN_CFG)    || (a == `OFF_DIR_CFG)   ||
             (a == `OFF_DRIVE_CFG)  || (a == `OFF_OUT_LEVELS) ||
             (a == `OFF_IN_LEVELS)  || (a == `OFF_GENERAL_CFG) ||
             (a == `OFF_STATUS)     || (a == `OFF_CONV_START);
  endfunction

  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Input synchroniser; only the second stage is read below
    s_d.in_s1 = chan_in;
    s_d.in_s2 = s_q.in_s1;
    // Error flag decided in the setup cycle and held through the access
    if (psel && !penable) begin
      s_d.pslverr = !mapped(paddr) || (pwrite &&
                    (paddr == `OFF_IN_LEVELS || paddr == `OFF_STATUS));
    end

    // Register writes, ignored while the soft reset runs
    if (wr_en && !s_q.rst_busy && pstrb[0]) begin
      unique case (paddr)
        `OFF_PIN_CFG:   s_d.pin_cfg = pwdata[7:0];
        `OFF_DIR_CFG:   s_d.dir_cfg = pwdata[7:0];
        `OFF_DRIVE_CFG: s_d.drive_cfg = pwdata[7:0];
        `OFF_OUT_LEVELS: s_d.out_levels = pwdata[7:0];
        `OFF_GENERAL_CFG: begin
          s_d.ref_en = pwdata[`GEN_REF_EN_BIT];
          if (pwdata[`GEN_RST_BIT]) begin
            s_d.rst_busy = 1'b1;
            s_d.rst_cnt  = 32'h0;
          end
        end
        `OFF_CONV_START: begin
          // Start a conversion only from acquisition
          if (pwdata[0] && s_q.phase == chan_cfg_pkg::PH_ACQ) begin
            s_d.phase    = chan_cfg_pkg::PH_CONV;
            s_d.conv_cnt = 16'h0;
          end
        end
        // Read-only or unmapped offsets: flagged in the setup cycle
        default: begin
        end
      endcase
    end

    if (s_q.phase == chan_cfg_pkg::PH_CONV) begin
      s_d.conv_cnt = s_q.conv_cnt + 16'h1;
      if (s_q.conv_cnt == 16'(CONV_CYCLES - 1)) begin
        s_d.phase = chan_cfg_pkg::PH_ACQ;
      end
    end

    // soft reset counts up to RST_CYCLES then clears its bit
    if (s_q.rst_busy) begin
      s_d.rst_cnt = s_q.rst_cnt + 32'h1;
      if (s_q.rst_cnt == 32'(RST_CYCLES - 1)) begin
        s_d.pin_cfg    = `RST_PIN_CFG;
        s_d.dir_cfg    = `RST_DIR_CFG;
        s_d.drive_cfg  = `RST_DRIVE_CFG;
        s_d.out_levels = `RST_OUT_LEVELS;
        s_d.ref_en     = `RST_REF_EN;
        s_d.phase      = chan_cfg_pkg::PH_ACQ;
        s_d.rst_busy   = 1'b0;
        s_d.rst_cnt    = 32'h0;
      end
    end

    // Read data, loaded in the setup cycle and held until the next read
    if (rd_setup) begin
      s_d.prdata = 32'h0;
      unique case (paddr)
        `OFF_PIN_CFG:    s_d.prdata[7:0] = s_q.pin_cfg;
        `OFF_DIR_CFG:    s_d.prdata[7:0] = s_q.dir_cfg;
        `OFF_DRIVE_CFG:  s_d.prdata[7:0] = s_q.drive_cfg;
        `OFF_OUT_LEVELS: s_d.prdata[7:0] = s_q.out_levels;
        `OFF_IN_LEVELS:
          s_d.prdata[7:0] = s_q.in_s2 & s_q.pin_cfg & ~s_q.dir_cfg;
        `OFF_GENERAL_CFG: begin
          s_d.prdata[`GEN_REF_EN_BIT] = s_q.ref_en;
          s_d.prdata[`GEN_RST_BIT]    = s_q.rst_busy;
        end
        `OFF_STATUS: begin
          s_d.prdata[`STAT_CONV_BIT] = (s_q.phase == chan_cfg_pkg::PH_CONV);
          s_d.prdata[`STAT_RST_BIT]  = s_q.rst_busy;
          s_d.prdata[`STAT_SW_BIT]   = s_q.sw_closed;
        end
        `OFF_CONV_START: s_d.prdata = 32'h0;
        default:         s_d.prdata = 32'h0;
      endcase
    end

    // drive only digital outputs; open-drain drives low only
    for (int i = 0; i < 8; i++) begin
      s_d.pins.out[i] = s_d.out_levels[i];
      s_d.pins.oe[i]  = s_d.pin_cfg[i] & s_d.dir_cfg[i] &
                        (s_d.drive_cfg[i] | ~s_d.out_levels[i]);
    end
    s_d.sw_closed = (s_d.phase == chan_cfg_pkg::PH_ACQ);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q            <= '0;
      s_q.pin_cfg    <= `RST_PIN_CFG;
      s_q.ref_en     <= `RST_REF_EN;
      s_q.phase      <= chan_cfg_pkg::PH_ACQ;
      s_q.sw_closed  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs from flip-flops; pslverr gated with psel and penable
  assign prdata          = s_q.prdata;
  assign pslverr         = s_q.pslverr & psel & penable;
  assign chan_out        = s_q.pins.out;
  assign chan_oe         = s_q.pins.oe;
  assign int_ref_enable  = s_q.ref_en;
  assign sampling_switch = s_q.sw_closed;
  assign converting      = (s_q.phase == chan_cfg_pkg::PH_CONV);
  assign device_reset    = s_q.rst_busy;

endmodule // chan_cfg

// *** core/chan_cfg_consts.svh ***
/*
  Offsets, field positions, reset values and timing counts of the
  channel configuration block.
  Assumes pclk at 100 MHz and a 32-bit APB register bus.
*/
`ifndef CHAN_CFG_CONSTS_SVH
`define CHAN_CFG_CONSTS_SVH

// Register byte offsets
`define OFF_PIN_CFG       12'h000
`define OFF_DIR_CFG       12'h004
`define OFF_DRIVE_CFG     12'h008
`define OFF_OUT_LEVELS    12'h00C
`define OFF_IN_LEVELS     12'h010
`define OFF_GENERAL_CFG   12'h014
`define OFF_STATUS        12'h018
`define OFF_CONV_START    12'h01C

// General configuration fields
`define GEN_RST_BIT       0
`define GEN_REF_EN_BIT    1

// Status fields
`define STAT_CONV_BIT     0
`define STAT_RST_BIT      1
`define STAT_SW_BIT       2

// Reset values
`define RST_PIN_CFG       8'h00
`define RST_DIR_CFG       8'h00
`define RST_DRIVE_CFG     8'h00
`define RST_OUT_LEVELS    8'h00
`define RST_REF_EN        1'b0

// Timing: clock period, reset and conversion figures
`define CLK_PERIOD_NS     10
`define RST_TIME_MS       5
`define CONV_TIME_NS      950
`define RST_CYCLES        ((`RST_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define CONV_CYCLES       (`CONV_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** core/chan_cfg_pkg.sv ***
/*
  Types of the channel configuration block.
  Assumes the constants header is included by the design file.
*/
package chan_cfg_pkg;

  // Conversion phase
  typedef enum logic [0:0] {
    PH_ACQ  = 1'b0,
    PH_CONV = 1'b1
  } phase_t;

  // Channel pin signals toward the pads
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0]  pin_cfg;
    logic [7:0]  dir_cfg;
    logic [7:0]  drive_cfg;
    logic [7:0]  out_levels;
    logic        ref_en;
    logic        rst_busy;
    logic [31:0] rst_cnt;
    phase_t      phase;
    logic [15:0] conv_cnt;
    logic [7:0]  in_s1;
    logic [7:0]  in_s2;
    logic [31:0] prdata;
    logic        pslverr;
    pin_drive_t  pins;
    logic        sw_closed;
  } state_t;

endpackage
